// >>> pkg/pdiom_pkg.sv
// Package for the programmable discrete I/O mapper: map, codes, resets, carriers
package pdiom_pkg;

  // ==========================================================================
  // Register map (byte addresses, one 32-bit word each)
  localparam logic [7:0] OFF_DI1_FN  = 8'h00;  // Input line 1 function setting
  localparam logic [7:0] OFF_DI2_FN  = 8'h04;  // Input line 2 function setting
  localparam logic [7:0] OFF_DI3_FN  = 8'h08;  // Input line 3 function setting
  localparam logic [7:0] OFF_DI4_FN  = 8'h0c;  // Input line 4 function setting
  localparam logic [7:0] OFF_DI5_FN  = 8'h10;  // Input line 5 function setting
  localparam logic [7:0] OFF_DO1_FN  = 8'h14;  // Output line 1 function setting
  localparam logic [7:0] OFF_DO2_FN  = 8'h18;  // Output line 2 function setting
  localparam logic [7:0] OFF_ZS_THR  = 8'h1c;  // Zero-speed threshold
  localparam logic [7:0] OFF_STATE   = 8'h20;  // Live state, read only
  localparam logic [7:0] OFF_IRQ_ST  = 8'h24;  // Sticky events, read only
  localparam logic [7:0] OFF_IRQ_CLR = 8'h28;  // Write one to clear, write only
  localparam logic [7:0] OFF_IRQ_EN  = 8'h2c;  // Interrupt enables

  // ==========================================================================
  // Function codes
  localparam logic [7:0] DI_ALARM_CLEAR = 8'h02;
  localparam logic [7:0] DI_EMERG_HALT  = 8'h21;
  localparam logic [7:0] DI_REV_LIMIT   = 8'h22;
  localparam logic [7:0] DI_FWD_LIMIT   = 8'h23;
  localparam logic [7:0] DO_DRIVE_READY = 8'h01;
  localparam logic [7:0] DO_ZERO_SPEED  = 8'h03;

  // ==========================================================================
  // Reset values; an input setting holds two codes, slot 0 low byte
  localparam logic [15:0] RST_DI1_FN = 16'h0000;
  localparam logic [15:0] RST_DI2_FN = 16'h0000;
  localparam logic [15:0] RST_DI3_FN = 16'h0022;
  localparam logic [15:0] RST_DI4_FN = 16'h0023;
  localparam logic [15:0] RST_DI5_FN = 16'h0221;
  localparam logic [7:0]  RST_DO1_FN = 8'h01;
  localparam logic [7:0]  RST_DO2_FN = 8'h03;
  localparam logic [15:0] RST_ZS_THR = 16'h000a;
  localparam logic [1:0]  RST_ENC_POS = 2'h0;  // Both positive legs low
  localparam logic [1:0]  RST_ENC_NEG = 2'h3;  // Both negative legs high

  // ==========================================================================
  // Field positions
  localparam int EV_ALARM_SET = 0;  // Alarm raised
  localparam int EV_ALARM_CLR = 1;  // Alarm cleared
  localparam int EV_ZS_ENTER  = 2;  // Motor reached zero speed
  localparam int ST_ALARM     = 0;  // State word: alarm bit
  localparam int ST_ZERO_SPEED_OUT      = 1;  // State word: zero-speed bit
  localparam int ST_DO_LSB    = 2;  // State word: output lines [3:2]
  localparam int ST_DI_LSB    = 4;  // State word: input lines [8:4]

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [7:0]  addr;   // Byte address
    logic [31:0] wdata;  // Write data
    logic        wr;     // Write strobe
    logic        rd;     // Read strobe
  } pdiom_bus_s;

  typedef struct packed {
    logic        powered;      // Drive power is up
    logic        ctrl_fault;   // Control circuit alarm
    logic        power_fault;  // Motor power circuit alarm
    logic [15:0] speed;        // Measured motor speed magnitude
    logic        enc_a;        // Quadrature A from position logic
    logic        enc_b;        // Quadrature B from position logic
  } pdiom_drv_s;

endpackage

// >>> rtl/pdiom_top.sv
// Programmable discrete I/O mapper: function decode, alarm, outputs, registers
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps

// Contract
// - Five input lines, two output lines
// - Per-line setting register selects its function
// - Input codes 02 clear, 21 halt, 22 reverse
// - Output codes 01 ready, 03 zero speed
// - Default mapping identical in every operating mode
// - Ready only when powered and alarm free
// - Zero speed when speed below threshold
// - Alarm clear resets alarm, ready returns
// - Emergency halt inactive raises alarm
// - Reverse limit inactive raises alarm
// - Forward limit code 23, inactive raises alarm
// - Encoder A/B as complementary pairs
module pdiom_top #(
  parameter int N_DI = 5,  // Input lines
  parameter int N_DO = 2   // Output lines
) (
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire pdiom_pkg::pdiom_bus_s bus,
  output logic [31:0]             rdata,
  input  wire pdiom_pkg::pdiom_drv_s drv,
  input  wire logic [N_DI-1:0]    di_line,
  output logic [N_DO-1:0]         do_line,
  output logic                    enc_a_pos,
  output logic                    enc_a_neg,
  output logic                    enc_b_pos,
  output logic                    enc_b_neg,
  output logic                    irq
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [N_DI-1:0][15:0] di_fn;    // Input function settings
    logic [N_DO-1:0][7:0]  do_fn;    // Output function settings
    logic [15:0]           zs_thr;   // Zero-speed threshold
    logic [N_DI-1:0]       di_q;     // Last input sample, for clear edge
    logic                  alarm;    // fault_alarm
    logic                  zero_speed_out;     // Speed below threshold
    logic [2:0]            ist;      // Sticky events
    logic [2:0]            ien;      // Event enables
    logic [N_DO-1:0]       do_out;   // Output lines
    logic [1:0]            enc_pos;  // A, B positive legs
    logic [1:0]            enc_neg;  // A, B negative legs
    logic                  irq;      // Interrupt level
    logic [31:0]           rdata;    // Read answer
  } pdiom_state_s;

  pdiom_state_s st_reg;   // Registered state
  pdiom_state_s st_next;  // Next state

  // ==========================================================================
  // Per-line function decode
  logic [N_DI-1:0] nc_open;    // Assigned contact-B function found open
  logic [N_DI-1:0] clr_edge;   // Alarm clear line just turned on

  genvar gi;
  generate
    for (gi = 0; gi < N_DI; gi++) begin : g_di
      logic [1:0] is_nc;  // Slot holds halt or a travel limit
      logic [1:0] is_clr; // Slot holds alarm clear
      for (genvar gs = 0; gs < 2; gs++) begin : g_slot
        // Unknown or zero codes match nothing, so stay inactive
        assign is_nc[gs] = (st_reg.di_fn[gi][gs*8 +: 8] == pdiom_pkg::DI_EMERG_HALT) ||
                           (st_reg.di_fn[gi][gs*8 +: 8] == pdiom_pkg::DI_REV_LIMIT)  ||
                           (st_reg.di_fn[gi][gs*8 +: 8] == pdiom_pkg::DI_FWD_LIMIT);
        assign is_clr[gs] = (st_reg.di_fn[gi][gs*8 +: 8] == pdiom_pkg::DI_ALARM_CLEAR);
      end
      // Contact B: a line off means broken circuit
      assign nc_open[gi]  = (|is_nc) && !di_line[gi];
      assign clr_edge[gi] = (|is_clr) && di_line[gi] && !st_reg.di_q[gi];
    end
  endgenerate

  // Alarm cause from contacts or from the drive's own circuits
  logic cause;
  assign cause = (|nc_open) || drv.ctrl_fault || drv.power_fault;

  // ==========================================================================
  // Next-state logic
  always_comb begin
    logic ready_n;   // Drive ready, next value
    logic [31:0] rd_v;  // Read mux
    logic [2:0] ev;  // Events this cycle
    ready_n = 1'b0;
    rd_v    = 32'h0000_0000;
    ev      = 3'h0;
    st_next = st_reg;
    st_next.di_q = di_line;

    // Register writes
    if (bus.wr) begin
      unique case (bus.addr)
        pdiom_pkg::OFF_DI1_FN: st_next.di_fn[0] = bus.wdata[15:0];
        pdiom_pkg::OFF_DI2_FN: st_next.di_fn[1] = bus.wdata[15:0];
        pdiom_pkg::OFF_DI3_FN: st_next.di_fn[2] = bus.wdata[15:0];
        pdiom_pkg::OFF_DI4_FN: st_next.di_fn[3] = bus.wdata[15:0];
        pdiom_pkg::OFF_DI5_FN: st_next.di_fn[4] = bus.wdata[15:0];
        pdiom_pkg::OFF_DO1_FN: st_next.do_fn[0] = bus.wdata[7:0];
        pdiom_pkg::OFF_DO2_FN: st_next.do_fn[1] = bus.wdata[7:0];
        pdiom_pkg::OFF_ZS_THR: st_next.zs_thr   = bus.wdata[15:0];
        pdiom_pkg::OFF_IRQ_EN: st_next.ien      = bus.wdata[2:0];
        default: ;  // Read-only, clear handled below, unmapped ignored
      endcase
    end

    // Alarm: a live cause wins over a clear in the same cycle
    if (cause) begin
      st_next.alarm = 1'b1;
    end else if (|clr_edge) begin
      st_next.alarm = 1'b0;
    end

    // Zero-speed compare, strictly below
    st_next.zero_speed_out = (drv.speed < st_reg.zs_thr);

    // Ready follows the alarm without extra lag
    ready_n = drv.powered && !st_next.alarm;

    // Output mapping per line
    for (int i = 0; i < N_DO; i++) begin
      if (st_reg.do_fn[i] == pdiom_pkg::DO_DRIVE_READY) begin
        st_next.do_out[i] = ready_n;
      end else if (st_reg.do_fn[i] == pdiom_pkg::DO_ZERO_SPEED) begin
        st_next.do_out[i] = st_next.zero_speed_out;
      end else begin
        st_next.do_out[i] = 1'b0;  // Unassigned output stays off
      end
    end

    // Encoder line driver pairs
    st_next.enc_pos = {drv.enc_b, drv.enc_a};
    st_next.enc_neg = {!drv.enc_b, !drv.enc_a};

    // Events; a new event beats a clear in the same cycle
    ev[pdiom_pkg::EV_ALARM_SET] = !st_reg.alarm && st_next.alarm;
    ev[pdiom_pkg::EV_ALARM_CLR] = st_reg.alarm && !st_next.alarm;
    ev[pdiom_pkg::EV_ZS_ENTER]  = !st_reg.zero_speed_out && st_next.zero_speed_out;
    if (bus.wr && (bus.addr == pdiom_pkg::OFF_IRQ_CLR)) begin
      st_next.ist = st_reg.ist & ~bus.wdata[2:0];
    end
    st_next.ist = st_next.ist | ev;
    st_next.irq = |(st_next.ist & st_next.ien);

    // Read answer, one cycle after the strobe
    if (bus.rd) begin
      unique case (bus.addr)
        pdiom_pkg::OFF_DI1_FN: rd_v = {16'h0000, st_reg.di_fn[0]};
        pdiom_pkg::OFF_DI2_FN: rd_v = {16'h0000, st_reg.di_fn[1]};
        pdiom_pkg::OFF_DI3_FN: rd_v = {16'h0000, st_reg.di_fn[2]};
        pdiom_pkg::OFF_DI4_FN: rd_v = {16'h0000, st_reg.di_fn[3]};
        pdiom_pkg::OFF_DI5_FN: rd_v = {16'h0000, st_reg.di_fn[4]};
        pdiom_pkg::OFF_DO1_FN: rd_v = {24'h000000, st_reg.do_fn[0]};
        pdiom_pkg::OFF_DO2_FN: rd_v = {24'h000000, st_reg.do_fn[1]};
        pdiom_pkg::OFF_ZS_THR: rd_v = {16'h0000, st_reg.zs_thr};
        pdiom_pkg::OFF_STATE: begin
          rd_v[pdiom_pkg::ST_ALARM] = st_reg.alarm;
          rd_v[pdiom_pkg::ST_ZERO_SPEED_OUT]  = st_reg.zero_speed_out;
          rd_v[pdiom_pkg::ST_DO_LSB +: N_DO] = st_reg.do_out;
          rd_v[pdiom_pkg::ST_DI_LSB +: N_DI] = st_reg.di_q;
        end
        pdiom_pkg::OFF_IRQ_ST: rd_v = {29'h0000_0000, st_reg.ist};
        pdiom_pkg::OFF_IRQ_EN: rd_v = {29'h0000_0000, st_reg.ien};
        default: rd_v = 32'h0000_0000;  // Unmapped and write-only read zero
      endcase
    end
    st_next.rdata = rd_v;
  end

  // ==========================================================================
  // State register; defaults same in every mode
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg          <= '0;
      st_reg.di_fn[0] <= pdiom_pkg::RST_DI1_FN;
      st_reg.di_fn[1] <= pdiom_pkg::RST_DI2_FN;
      st_reg.di_fn[2] <= pdiom_pkg::RST_DI3_FN;
      st_reg.di_fn[3] <= pdiom_pkg::RST_DI4_FN;
      st_reg.di_fn[4] <= pdiom_pkg::RST_DI5_FN;
      st_reg.do_fn[0] <= pdiom_pkg::RST_DO1_FN;
      st_reg.do_fn[1] <= pdiom_pkg::RST_DO2_FN;
      st_reg.zs_thr   <= pdiom_pkg::RST_ZS_THR;
      st_reg.enc_pos  <= pdiom_pkg::RST_ENC_POS;
      st_reg.enc_neg  <= pdiom_pkg::RST_ENC_NEG;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state flops
  assign rdata     = st_reg.rdata;
  assign do_line   = st_reg.do_out;
  assign enc_a_pos = st_reg.enc_pos[0];
  assign enc_b_pos = st_reg.enc_pos[1];
  assign enc_a_neg = st_reg.enc_neg[0];
  assign enc_b_neg = st_reg.enc_neg[1];
  assign irq       = st_reg.irq;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_READY_GATED: assert property (
    (st_reg.do_fn[0] == pdiom_pkg::DO_DRIVE_READY) && !$changed(st_reg.do_fn[0]) && do_line[0]
      |-> $past(drv.powered) && !st_reg.alarm)
    else $error("Ready output high while unpowered or alarmed");

  AST_ALARM_ON_OPEN: assert property (
    (|nc_open) |=> st_reg.alarm && (st_reg.do_out[0] == 1'b0 ||
      st_reg.do_fn[0] != pdiom_pkg::DO_DRIVE_READY))
    else $error("Open contact did not raise the alarm");

  AST_FWD_DEFAULT: assert property (
    (st_reg.di_fn[3] == pdiom_pkg::RST_DI4_FN) && !di_line[3] |=> st_reg.alarm)
    else $error("Forward limit open did not alarm");

  AST_REV_DEFAULT: assert property (
    (st_reg.di_fn[2] == pdiom_pkg::RST_DI3_FN) && !di_line[2] |=> st_reg.alarm)
    else $error("Reverse limit open did not alarm");

  AST_CLEAR: assert property (
    st_reg.alarm && (|clr_edge) && !cause |=> !st_reg.alarm)
    else $error("Alarm clear edge did not clear the alarm");

  AST_UNASSIGNED: assert property (
    !st_reg.alarm && !cause && !$past(cause) |=> !st_reg.alarm)
    else $error("Alarm rose with no assigned open contact or fault");

  // The first edge out of reset still shows the reset flag, not a compare
  AST_ZERO_SPEED_OUT: assert property (
    $past(rstn) && !$changed(st_reg.zs_thr) |->
      st_reg.zero_speed_out == ($past(drv.speed) < st_reg.zs_thr))
    else $error("Zero-speed flag disagrees with threshold compare");

  AST_ENC_PAIR: assert property (
    (enc_a_pos != enc_a_neg) && (enc_b_pos != enc_b_neg) &&
      (enc_a_pos == $past(drv.enc_a)) && (enc_b_pos == $past(drv.enc_b)))
    else $error("Encoder pair not complementary or not tracking");

  AST_IRQ_LEVEL: assert property (
    irq == |(st_reg.ist & st_reg.ien))
    else $error("Interrupt level does not match enabled status");

  AST_WRITE_MAP: assert property (
    bus.wr && (bus.addr == pdiom_pkg::OFF_DO2_FN) |=> st_reg.do_fn[1] == $past(bus.wdata[7:0]))
    else $error("Output 2 setting not taken from write");

  COV_ALARM_CLEARED: cover property (st_reg.alarm ##[1:20] !st_reg.alarm);
  COV_ZS_IRQ:        cover property (st_reg.ist[pdiom_pkg::EV_ZS_ENTER] && irq);
  COV_REMAP_READY:   cover property (st_reg.do_fn[1] == pdiom_pkg::DO_DRIVE_READY && do_line[1]);

endmodule // pdiom_top

// >>> sim/pdiom_field.sv
// Field side model: contacts on the discrete inputs and the drive status feed
`timescale 1ns/1ps

module pdiom_field (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [4:0]       opened,   // Contacts the bench has opened
  input  wire logic             pwr,      // Drive power up
  input  wire logic [1:0]       flt,      // Control and power circuit faults
  input  wire logic [15:0]      spd,      // Motor speed to report
  output logic [4:0]            di_line,  // Contact levels, 1 = ON
  output pdiom_pkg::pdiom_drv_s drv       // Drive status and quadrature
);
  logic [1:0] ph;  // Quadrature phase

  // ==========================================================================
  // Levels change just after an edge, as a real contact would be seen
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ph      <= 2'h0;
      di_line <= 5'h1f;  // Closed contacts stay ON
      drv     <= '0;
    end else begin
      ph      <= ph + 2'h1;  // Free running, so A and B keep moving
      di_line <= ~opened;    // Five lines, opened only on command
      drv     <= '{powered: pwr, ctrl_fault: flt[0], power_fault: flt[1],
                   speed: spd, enc_a: ph[1], enc_b: ph[1] ^ ph[0]};
    end
  end
endmodule  // pdiom_field

// >>> sim/pdiom_top_test.sv
// Self-checking bench for the discrete I/O mapper
`timescale 1ns/1ps

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

module pdiom_top_test;
  logic                  clk, rstn;         // 20 MHz clock, reset
  pdiom_pkg::pdiom_bus_s bus;               // Register requests
  logic [31:0]           rdata, e_rd;       // Read data, expected
  pdiom_pkg::pdiom_drv_s drv;               // Drive status feed
  logic [4:0]            di_line, opened;   // Input lines, opened contacts
  logic [1:0]            do_line, flt;      // Output lines, faults
  logic                  eap, ean, ebp, ebn, irq, pwr, rd_d, ea_d, eb_d;
  logic [15:0]           spd, thr;          // Speed, threshold
  logic [31:0]           exp_q[$];          // Expected read data, oldest first
  logic [31:0]           rv[8] = '{32'h0, 32'h0, 32'h22, 32'h23, 32'h221, 32'h1,
                                   32'h3, 32'ha};
  int                    n_errors = 0, n_checks = 0, cycles = 0;

  pdiom_top pdiom_top_i (.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata), .drv(drv),
    .di_line(di_line), .do_line(do_line), .enc_a_pos(eap), .enc_a_neg(ean),
    .enc_b_pos(ebp), .enc_b_neg(ebn), .irq(irq));
  pdiom_field pdiom_field_i (.clk(clk), .rstn(rstn), .opened(opened), .pwr(pwr),
    .flt(flt), .spd(spd), .di_line(di_line), .drv(drv));

  // ==========================================================================
  // Clock, history and hang guard
  always #25 clk = ~clk;
  always @(posedge clk) begin
    rd_d <= bus.rd;
    ea_d <= drv.enc_a;
    eb_d <= drv.enc_b;
    cycles <= cycles + 1;
    if (cycles == 8000) begin  // Far beyond the few hundred cycles needed
      n_errors++;
      conclude();
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(negedge clk) begin
    if (rd_d === 1'b1) begin
      e_rd = exp_q.pop_front();
      `CHK(rdata, e_rd)
    end
  end

  // ==========================================================================
  // Bus and field tasks; each starts at an edge, so strobes never clash
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    exp_q.push_back(e);
    @(posedge clk);
    bus <= '0;
  endtask
  // Field levels, then a settle long enough for model and design stages
  task automatic fld(input logic [4:0] o, input logic [1:0] f, input logic p,
                     input logic [15:0] s);
    @(posedge clk);
    opened <= o;
    flt <= f;
    pwr <= p;
    spd <= s;
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic note(input string s);
    $display("Test done: %s", s);
  endtask
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    bus = '0;
    opened = '0;
    pwr = 1'b1;
    flt = '0;
    spd = 16'h0064;
    void'($urandom(32'h1c13));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    // Default settings, then places that must read zero
    foreach (rv[i]) begin
      rd(8'(i * 4), rv[i]);
    end
    rd(pdiom_pkg::OFF_IRQ_CLR, 32'h0);
    rd(8'h40, 32'h0);
    note("reset values");
    // Ready follows power; zero speed is strict below threshold
    fld(5'h00, 2'h0, 1'b1, 16'h0064);
    `CHK(do_line, 2'b01)
    fld(5'h00, 2'h0, 1'b0, 16'h0004);
    `CHK(do_line, 2'b10)
    for (int i = 0; i < 6; i++) begin  // First pass hits speed equal to threshold
      thr = 16'($urandom_range(40, 1));
      wr(pdiom_pkg::OFF_ZS_THR, {16'h0, thr});
      fld(5'h00, 2'h0, 1'b1, (i == 0) ? thr : 16'($urandom_range(40, 0)));
      `CHK(do_line[1], spd < thr)
    end
    note("ready and zero speed");
    // Each default contact opened in turn, then cleared from line five
    wr(pdiom_pkg::OFF_IRQ_CLR, 32'h7);
    wr(pdiom_pkg::OFF_IRQ_EN, 32'h7);
    for (int k = 2; k < 5; k++) begin
      fld(5'(1 << k), 2'h0, 1'b1, 16'hffff);
      `CHK({irq, do_line[0]}, 2'b10)
      fld(5'h00, 2'h0, 1'b1, 16'hffff);
      `CHK(do_line[0], k == 4)
      fld(5'h10, 2'h0, 1'b1, 16'hffff);
      fld(5'h00, 2'h0, 1'b1, 16'hffff);
      `CHK(do_line[0], 1'b1)
    end
    rd(pdiom_pkg::OFF_IRQ_ST, 32'h3);
    wr(pdiom_pkg::OFF_IRQ_CLR, 32'h7);
    for (int f = 1; f < 3; f++) begin  // Control, then power circuit fault
      fld(5'h00, 2'(f), 1'b1, 16'hffff);
      `CHK({irq, do_line[0]}, 2'b10)
      fld(5'h10, 2'h0, 1'b1, 16'hffff);
      fld(5'h00, 2'h0, 1'b1, 16'hffff);
      `CHK(do_line[0], 1'b1)
      wr(pdiom_pkg::OFF_IRQ_CLR, 32'h7);
    end
    wr(pdiom_pkg::OFF_IRQ_EN, 32'h0);
    fld(5'h08, 2'h0, 1'b1, 16'hffff);
    `CHK({irq, do_line[0]}, 2'b00)
    rd(pdiom_pkg::OFF_IRQ_ST, 32'h1);
    fld(5'h10, 2'h0, 1'b1, 16'hffff);
    fld(5'h00, 2'h0, 1'b1, 16'hffff);
    note("alarms and interrupt");
    // Clear moved to line one, line three left without a function
    wr(pdiom_pkg::OFF_DI1_FN, 32'h02);
    wr(pdiom_pkg::OFF_DI5_FN, 32'h21);
    wr(pdiom_pkg::OFF_DI3_FN, 32'h00);
    fld(5'h04, 2'h0, 1'b1, 16'hffff);
    `CHK(do_line[0], 1'b1)
    fld(5'h18, 2'h0, 1'b1, 16'hffff);
    fld(5'h00, 2'h0, 1'b1, 16'hffff);
    `CHK(do_line[0], 1'b0)
    fld(5'h01, 2'h0, 1'b1, 16'hffff);
    fld(5'h00, 2'h0, 1'b1, 16'hffff);
    `CHK(do_line[0], 1'b1)
    wr(pdiom_pkg::OFF_DO1_FN, 32'h03);
    wr(pdiom_pkg::OFF_DO2_FN, 32'h01);
    fld(5'h00, 2'h0, 1'b1, 16'hffff);
    `CHK(do_line, 2'b10)
    wr(pdiom_pkg::OFF_DO2_FN, 32'h55);
    rd(pdiom_pkg::OFF_DO2_FN, 32'h55);
    fld(5'h00, 2'h0, 1'b1, 16'h0000);
    `CHK(do_line, 2'b01)
    note("remapping");
    // Encoder legs copy the source one edge late, negatives inverted
    repeat (8) begin
      @(negedge clk);
      `CHK({eap, ean, ebp, ebn}, {ea_d, ~ea_d, eb_d, ~eb_d})
    end
    note("encoder");
    conclude();
  end
endmodule  // pdiom_top_test
